// ### logic/loop_slave_seq.sv
// Sequencing and control logic of the telset-side loop transceiver
//
// Behaviour
// - Transmit window high eight clocks after demodulation
// - Shift demodulated word out on rising clocks
// - PCM output released while transmit window low
// - Receive window is inverse of transmit window
// - Sample PCM input on eight falling clocks
// - Data clock 128 kHz, starts on demodulation
// - Clock stops low after sixteen periods
// - Signalling outputs and valid update at window rise
// - Valid only for good sync, no errors
// - Silence of 250 us clears valid flag
// - Capture signalling inputs at window rise
// - Power-down stops transmission, keeps receive side
// - Powered up: answer every master burst
// - Free-run 125 us clock, burst every other
// - Weakly drive power-down pin from line activity
// - Tone request substitutes 500 Hz square wave
// - Tone request alone makes windows and clock
// - Tone coded mu-law on 1, A-law 0
// - Loop-back returns demodulated voice to master
// - Loop-back holds data clock low
// - Burst starts four line bits after demodulation
// - Clock is oscillator over 32, slip absorbed
`default_nettype none
`include "loop_slave_consts.svh"

module loop_slave_seq #(
   parameter logic [15:0] SILENCE_CYCLES   = 16'(`SILENCE_CYCLES),
   parameter logic [15:0] TICK_CYCLES      = 16'(`TICK_CYCLES),
   parameter logic [15:0] TONE_HALF_CYCLES = 16'(`TONE_HALF_CYCLES)
) (
   input  wire logic                    i_clock,
   input  wire logic                    i_resetn,
   input  wire loop_slave_pkg::demod_t  i_demod,
   output logic                         o_burst_valid,
   output loop_slave_pkg::burst_t       o_burst,
   input  wire logic                    i_burst_ready,
   input  wire logic                    i_pcm_in,
   output logic                         o_pcm_out,
   output logic                         o_pcm_out_en,
   output logic                         o_transmit_window,
   output logic                         o_receive_window,
   output logic                         o_data_clock,
   input  wire logic                    i_sig_in_a,
   input  wire logic                    i_sig_in_b,
   output logic                         o_sig_out_a,
   output logic                         o_sig_out_b,
   output logic                         o_valid_frame,
   input  wire logic                    i_power_down_n,
   output logic                         o_power_down_n,
   output logic                         o_power_down_n_en,
   input  wire logic                    i_tone_request,
   input  wire logic                    i_loopback_n,
   input  wire logic                    i_companding_law_select
);

   // -------------------------------------------------------------------------
   // Derived counts
   // -------------------------------------------------------------------------
   localparam logic [7:0]  HALF_LAST  = 8'(`DCLK_HALF_CYCLES - 1);
   localparam logic [9:0]  BURST_LAST = 10'(`BURST_DELAY_CYCLES - 1);

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [15:0]            sil_cnt;
      logic                   silent;
      logic [15:0]            tick_cnt;
      logic                   tick_odd;
      logic [15:0]            tone_cnt;
      logic                   tone_pos;
      logic                   frame_on;
      logic [7:0]             half_cnt;
      logic [4:0]             half_idx;
      logic                   tx_win;
      logic                   rx_win;
      logic                   dclk;
      logic [7:0]             tx_sh;
      logic                   pcm_out;
      logic [7:0]             rx_sh;
      logic [7:0]             rx_word;
      logic [1:0]             sig_out;
      logic                   valid;
      logic [1:0]             sig_cap;
      logic                   burst_wait;
      logic [9:0]             burst_cnt;
      logic [7:0]             burst_voice;
      logic                   push_pend;
      loop_slave_pkg::burst_t push_word;
      loop_slave_pkg::burst_t ent0;
      loop_slave_pkg::burst_t ent1;
      logic                   v0;
      logic                   v1;
      logic                   pd_out;
      logic                   pd_en;
   } state_t;

   state_t s_reg;
   state_t s_next;

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   // A new demodulation always restarts the frame, which is what soaks up
   // clock slip between the two ends.
   always_comb
   begin
      logic       powered;
      logic       tick;
      logic       demod_start;
      logic       tone_start;
      logic       free_burst;
      logic [7:0] tone_word;
      logic [7:0] out_word;
      logic       room;
      logic       do_push;
      logic       fresh;

      s_next      = s_reg;
      powered     = i_power_down_n;
      tick        = 1'b0;
      demod_start = i_demod.done;
      tone_start  = 1'b0;
      free_burst  = 1'b0;
      tone_word   = 8'h00;
      out_word    = 8'h00;
      room        = 1'b0;
      do_push     = 1'b0;
      fresh       = 1'b0;

      // Silence watch, restarted by each completed demodulation
      if (i_demod.done)
      begin
         s_next.sil_cnt = 16'h0000;
         s_next.silent  = 1'b0;
         s_next.pd_out  = 1'b1;
         s_next.pd_en   = 1'b1;
      end
      else if (!s_reg.silent)
      begin
         if (s_reg.sil_cnt == SILENCE_CYCLES - 16'h0001)
         begin
            s_next.silent = 1'b1;
            s_next.valid  = 1'b0;
            s_next.pd_out = 1'b0;
            s_next.pd_en  = 1'b1;
         end
         else
         begin
            s_next.sil_cnt = s_reg.sil_cnt + 16'h0001;
         end
      end

      // Free-running 125 us clock while the line is silent
      if (s_reg.silent && !i_demod.done && (powered || i_tone_request))
      begin
         if (s_reg.tick_cnt == TICK_CYCLES - 16'h0001)
         begin
            s_next.tick_cnt = 16'h0000;
            s_next.tick_odd = !s_reg.tick_odd;
            tick            = 1'b1;
         end
         else
         begin
            s_next.tick_cnt = s_reg.tick_cnt + 16'h0001;
         end
      end
      else
      begin
         s_next.tick_cnt = 16'h0000;
         s_next.tick_odd = 1'b0;
      end
      tone_start = tick && i_tone_request;
      free_burst = tick && s_reg.tick_odd && powered;

      // Tone square wave, always running so its phase stays steady
      if (s_reg.tone_cnt == TONE_HALF_CYCLES - 16'h0001)
      begin
         s_next.tone_cnt = 16'h0000;
         s_next.tone_pos = !s_reg.tone_pos;
      end
      else
      begin
         s_next.tone_cnt = s_reg.tone_cnt + 16'h0001;
      end
      if (i_companding_law_select)
         tone_word = s_reg.tone_pos ? `TONE_MU_POS : `TONE_MU_NEG;
      else
         tone_word = s_reg.tone_pos ? `TONE_A_POS : `TONE_A_NEG;
      out_word = i_tone_request ? tone_word : i_demod.voice;

      // Data clock half periods; loop-back keeps the pin low
      if (s_reg.frame_on)
      begin
         if (s_reg.half_cnt == HALF_LAST)
         begin
            s_next.half_cnt = 8'h00;
            if (s_reg.half_idx == `FRAME_LAST_HALF)
            begin
               s_next.frame_on = 1'b0;
               s_next.dclk     = 1'b0;
               s_next.rx_word  = s_reg.rx_sh;
            end
            else
            begin
               s_next.half_idx = s_reg.half_idx + 5'h01;
               if (!s_next.half_idx[0])
               begin
                  s_next.dclk = i_loopback_n;
                  if (s_next.half_idx == `TX_END_HALF)
                  begin
                     s_next.tx_win = 1'b0;
                     s_next.rx_win = 1'b1;
                  end
                  else
                  begin
                     s_next.pcm_out = s_reg.tx_sh[7];
                     s_next.tx_sh   = {s_reg.tx_sh[6:0], 1'b0};
                  end
               end
               else
               begin
                  s_next.dclk = 1'b0;
                  if (s_next.half_idx > `TX_END_HALF)
                     s_next.rx_sh = {s_reg.rx_sh[6:0], i_pcm_in};
               end
            end
         end
         else
         begin
            s_next.half_cnt = s_reg.half_cnt + 8'h01;
         end
      end

      // Frame start, by demodulation or by the free-running 125 us tick under tone request
      if (demod_start || tone_start)
      begin
         s_next.frame_on = 1'b1;
         s_next.half_cnt = 8'h00;
         s_next.half_idx = 5'h00;
         s_next.tx_win   = 1'b1;
         s_next.rx_win   = 1'b0;
         s_next.dclk     = i_loopback_n;
         s_next.pcm_out  = out_word[7];
         s_next.tx_sh    = {out_word[6:0], 1'b0};
         s_next.sig_cap  = {i_sig_in_b, i_sig_in_a};
      end
      // Loop-back pulls the pin low at once, not at the next half boundary
      if (!i_loopback_n)
         s_next.dclk = 1'b0;
      if (demod_start)
      begin
         s_next.sig_out = i_demod.sig;
         s_next.valid   = i_demod.valid;
      end
      if (tick)
         s_next.sig_cap = {i_sig_in_b, i_sig_in_a};

      // Return burst: armed by demodulation when powered up
      if (demod_start && powered)
      begin
         s_next.burst_wait  = 1'b1;
         s_next.burst_cnt   = 10'h000;
         s_next.burst_voice = i_loopback_n ? s_reg.rx_word : i_demod.voice;
      end
      else if (s_reg.burst_wait)
      begin
         if (s_reg.burst_cnt == BURST_LAST)
         begin
            s_next.burst_wait      = 1'b0;
            s_next.push_pend       = 1'b1;
            s_next.push_word.voice = s_reg.burst_voice;
            s_next.push_word.sig   = s_reg.sig_cap;
            fresh                  = 1'b1;
         end
         else
         begin
            s_next.burst_cnt = s_reg.burst_cnt + 10'h001;
         end
      end
      if (free_burst)
      begin
         s_next.push_pend       = 1'b1;
         s_next.push_word.voice = s_reg.rx_word;
         s_next.push_word.sig   = {i_sig_in_b, i_sig_in_a};
         fresh                  = 1'b1;
      end
      if (!powered)
      begin
         s_next.burst_wait = 1'b0;
         s_next.push_pend  = 1'b0;
      end

      // Two-entry buffer; a pending burst waits while it is full
      room    = !s_reg.v1;
      do_push = s_reg.push_pend && room && powered;
      if (i_burst_ready && s_reg.v0)
      begin
         s_next.ent0 = s_reg.ent1;
         s_next.v0   = s_reg.v1;
         s_next.v1   = 1'b0;
      end
      if (do_push)
      begin
         // A burst loaded in this same cycle stays pending behind the old one
         if (!fresh)
            s_next.push_pend = 1'b0;
         if (!s_next.v0)
         begin
            s_next.ent0 = s_reg.push_word;
            s_next.v0   = 1'b1;
         end
         else
         begin
            s_next.ent1 = s_reg.push_word;
            s_next.v1   = 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         s_reg        <= '0;
         s_reg.rx_win <= 1'b1;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs, all straight from the state register
   // -------------------------------------------------------------------------
   assign o_burst_valid     = s_reg.v0;
   assign o_burst           = s_reg.ent0;
   assign o_pcm_out         = s_reg.pcm_out;
   assign o_pcm_out_en      = s_reg.tx_win;
   assign o_transmit_window = s_reg.tx_win;
   assign o_receive_window  = s_reg.rx_win;
   assign o_data_clock      = s_reg.dclk;
   assign o_sig_out_a       = s_reg.sig_out[0];
   assign o_sig_out_b       = s_reg.sig_out[1];
   assign o_valid_frame     = s_reg.valid;
   assign o_power_down_n    = s_reg.pd_out;
   assign o_power_down_n_en = s_reg.pd_en;

endmodule : loop_slave_seq
`default_nettype wire

// ### logic/loop_slave_consts.svh
// Timing counts, code points and field positions of the loop transceiver slave sequencer
`ifndef LOOP_SLAVE_CONSTS_SVH
`define LOOP_SLAVE_CONSTS_SVH

// ----------------------------------------------------------------------------
// Clock and derived rates
// ----------------------------------------------------------------------------
`define CLK_HZ            50000000
`define OSC_HZ            4096000
`define DCLK_DIV          32
`define DCLK_HZ           (`OSC_HZ / `DCLK_DIV)
`define DCLK_HALF_CYCLES  (`CLK_HZ / (2 * `DCLK_HZ))
`define LINE_BIT_HZ       256000
`define BURST_DELAY_BITS  4
`define BURST_DELAY_CYCLES ((`BURST_DELAY_BITS * `CLK_HZ + `LINE_BIT_HZ - 1) / `LINE_BIT_HZ)

// ----------------------------------------------------------------------------
// Long times, in microseconds and hertz, and their cycle counts
// ----------------------------------------------------------------------------
`define SILENCE_US        250
`define SILENCE_CYCLES    (`SILENCE_US * (`CLK_HZ / 1000000))
`define TICK_US           125
`define TICK_CYCLES       (`TICK_US * (`CLK_HZ / 1000000))
`define TONE_HZ           500
`define TONE_HALF_CYCLES  (`CLK_HZ / (2 * `TONE_HZ))

// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define WORD_BITS         8
`define TX_LAST_HALF      5'h0F
`define TX_END_HALF       5'h10
`define FRAME_LAST_HALF   5'h1F

// ----------------------------------------------------------------------------
// Tone code points: positive and negative half of the square wave
// ----------------------------------------------------------------------------
`define TONE_MU_POS       8'hA2
`define TONE_MU_NEG       8'h22
`define TONE_A_POS        8'hB8
`define TONE_A_NEG        8'h38

`endif

// ### logic/loop_slave_pkg.sv
// Types shared by the loop transceiver slave sequencer and its surroundings
`default_nettype none
package loop_slave_pkg;

   // Completion report from the demodulator
   typedef struct packed {
      logic       done;
      logic [7:0] voice;
      logic [1:0] sig;
      logic       valid;
   } demod_t;

   // One burst's payload for the modulator
   typedef struct packed {
      logic [7:0] voice;
      logic [1:0] sig;
   } burst_t;

endpackage : loop_slave_pkg
`default_nettype wire

// ### bench/loop_slave_seq_checker.sv
// Port-level assertions for the loop transceiver slave sequencer
`default_nettype none
module loop_slave_seq_checker (
   input wire logic                   i_clock,
   input wire logic                   i_resetn,
   input wire loop_slave_pkg::demod_t i_demod,
   input wire logic                   o_burst_valid,
   input wire loop_slave_pkg::burst_t o_burst,
   input wire logic                   i_burst_ready,
   input wire logic                   o_pcm_out_en,
   input wire logic                   o_transmit_window,
   input wire logic                   o_receive_window,
   input wire logic                   o_data_clock,
   input wire logic                   o_sig_out_a,
   input wire logic                   o_sig_out_b,
   input wire logic                   o_valid_frame,
   input wire logic                   o_power_down_n,
   input wire logic                   o_power_down_n_en,
   input wire logic                   i_tone_request,
   input wire logic                   i_loopback_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] win_cnt_reg;
   logic [15:0] high_cnt_reg;

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_resetn);

   // A strobe clears the counts, so a demodulated frame counts like a tone frame
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         win_cnt_reg  <= 16'h0000;
         high_cnt_reg <= 16'h0000;
      end
      else
      begin
         win_cnt_reg  <= i_demod.done ? 16'h0000 :
                         (o_transmit_window ? win_cnt_reg + 16'h0001 : 16'h0000);
         high_cnt_reg <= i_demod.done ? 16'h0000 :
                         (o_data_clock ? high_cnt_reg + 16'h0001 : 16'h0000);
      end
   end

   // ---------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------
   a_window_inverse: assert property (o_receive_window == !o_transmit_window)
      else $error("receive window is not the inverse of transmit window");
   a_window_rise: assert property (i_demod.done |=> o_transmit_window)
      else $error("transmit window did not open after strobe");
   a_window_length: assert property ($fell(o_transmit_window) |-> win_cnt_reg == 16'h0C30)
      else $error("transmit window length is not sixteen clock halves");
   a_pcm_release: assert property (o_pcm_out_en == o_transmit_window)
      else $error("serial output driven outside the transmit window");
   a_sig_update: assert property (i_demod.done |=> {o_sig_out_b, o_sig_out_a} == $past(i_demod.sig))
      else $error("signalling outputs not updated at window rise");
   a_valid_update: assert property (i_demod.done |=> o_valid_frame == $past(i_demod.valid))
      else $error("valid flag does not follow frame validity");
   a_window_cause: assert property ($rose(o_transmit_window) |->
      $past(i_demod.done) || $past(i_tone_request))
      else $error("transmit window opened without strobe or tone");
   a_clock_start: assert property (i_demod.done && i_loopback_n |=> o_data_clock)
      else $error("data clock did not start with the frame");
   a_clock_half: assert property ($fell(o_data_clock) |-> high_cnt_reg == 16'h00C3)
      else $error("data clock high half has the wrong length");
   a_loop_quiet: assert property (!i_loopback_n && $past(!i_loopback_n) |-> !o_data_clock)
      else $error("data clock active during loop-back");
   a_weak_high: assert property (i_demod.done |=> o_power_down_n && o_power_down_n_en)
      else $error("power-down pin not driven high after a strobe");
   a_burst_hold: assert property (o_burst_valid && !i_burst_ready |=>
      o_burst_valid && $stable(o_burst))
      else $error("offered burst changed before it was taken");
endmodule : loop_slave_seq_checker

bind loop_slave_seq loop_slave_seq_checker chk (
   .i_clock, .i_resetn, .i_demod, .o_burst_valid, .o_burst, .i_burst_ready, .o_pcm_out_en,
   .o_transmit_window, .o_receive_window, .o_data_clock, .o_sig_out_a, .o_sig_out_b,
   .o_valid_frame, .o_power_down_n, .o_power_down_n_en, .i_tone_request, .i_loopback_n
);
`default_nettype wire

// ### bench/codec_model.sv
// Behavioural codec serial port facing the sequencer
`default_nettype none
module codec_model (
   input  wire logic       i_clock,
   input  wire logic       i_data_clock,
   input  wire logic       i_transmit_window,
   input  wire logic       i_receive_window,
   input  wire logic       i_pcm_out,
   input  wire logic       i_pcm_out_en,
   input  wire logic [7:0] i_word,
   output logic            o_pcm_in,
   output logic [7:0]      o_heard
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] shift_reg;
   logic       noise_reg = 1'b0;

   // Outside its slot the line toggles, so a stale bit is never sampled
   always @(posedge i_clock)
      noise_reg <= ~noise_reg;
   assign o_pcm_in = i_receive_window ? shift_reg[7] : noise_reg;

   // Word loads as the slot opens; next bit appears just after each fall
   always @(posedge i_receive_window)
      shift_reg <= i_word;
   always @(negedge i_data_clock)
   begin
      if (i_receive_window)
         shift_reg <= #5 {shift_reg[6:0], 1'b0};
      if (i_transmit_window && i_pcm_out_en)
         o_heard <= {o_heard[6:0], i_pcm_out};
   end
endmodule : codec_model
`default_nettype wire

// ### bench/tb_loop_slave_seq.sv
// Self-checking bench for the loop transceiver slave sequencer
`default_nettype none
`include "loop_slave_consts.svh"
module tb_loop_slave_seq;
   timeunit 1ns;
   timeprecision 1ps;
   logic                   clock = 1'b0;
   logic                   resetn, burst_ready, sig_a, sig_b, tone, lb_n, law, pd_ext, pd_ext_en;
   logic                   burst_valid, pcm_in, pcm_out, pcm_en, tx_win, rx_win, dclk;
   logic                   sig_out_a, sig_out_b, valid_frame, pd_out, pd_en;
   logic [7:0]             word, heard, pos, neg;
   loop_slave_pkg::demod_t demod;
   loop_slave_pkg::burst_t burst;
   wire logic              pd_pin;
   int                     miscompares = 0, samples_checked = 0, cycles = 0, waited;

   // External driver overrides the weak drive; an idle pin floats high
   assign pd_pin = pd_ext_en ? pd_ext : (pd_en ? pd_out : 1'b1);
   always #10 clock = ~clock;

   loop_slave_seq #(.TONE_HALF_CYCLES(16'h0014)) dut (
      .i_clock(clock), .i_resetn(resetn), .i_demod(demod), .o_burst_valid(burst_valid),
      .o_burst(burst), .i_burst_ready(burst_ready), .i_pcm_in(pcm_in), .o_pcm_out(pcm_out),
      .o_pcm_out_en(pcm_en), .o_transmit_window(tx_win), .o_receive_window(rx_win),
      .o_data_clock(dclk), .i_sig_in_a(sig_a), .i_sig_in_b(sig_b), .o_sig_out_a(sig_out_a),
      .o_sig_out_b(sig_out_b), .o_valid_frame(valid_frame), .i_power_down_n(pd_pin),
      .o_power_down_n(pd_out), .o_power_down_n_en(pd_en), .i_tone_request(tone),
      .i_loopback_n(lb_n), .i_companding_law_select(law));

   codec_model codec (
      .i_clock(clock), .i_data_clock(dclk), .i_transmit_window(tx_win),
      .i_receive_window(rx_win), .i_pcm_out(pcm_out), .i_pcm_out_en(pcm_en),
      .i_word(word), .o_pcm_in(pcm_in), .o_heard(heard));

   // ---------------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Outputs are read 1 ns after the answering edge, once they have landed
   task automatic strobe(input logic [7:0] voice, input logic [1:0] sig, input logic valid);
      @(posedge clock);
      demod <= '{1'b1, voice, sig, valid};
      @(posedge clock);
      demod.done <= 1'b0;
      #1;
   endtask : strobe

   // Ready is held for exactly the one edge that takes the offered burst
   task automatic pop(input logic [7:0] voice, input logic [1:0] sig, output int n);
      n = 0;
      @(posedge clock);
      while (burst_valid !== 1'b1 && n < 14000)
      begin
         n++;
         @(posedge clock);
      end
      check({6'h00, burst}, {6'h00, voice, sig});
      burst_ready <= 1'b1;
      @(posedge clock);
      burst_ready <= 1'b0;
   endtask : pop

   task automatic tally_and_finish;
      $display("checked %0d, mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish

   // Hang guard, sized a little above the full sequence
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 100000)
      begin
         miscompares++;
         tally_and_finish();
      end
   end

   // ---------------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------------
   initial
   begin
      {resetn, sig_a, sig_b, tone, law, lb_n, pd_ext, pd_ext_en, burst_ready} = 9'h01F;
      demod = '0;
      word = 8'h30;
      repeat (20) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      #1;
      check(16'({rx_win, tx_win, valid_frame, pd_en}), 16'h0008);
      strobe(8'hA5, 2'b10, 1'b1);
      check(16'({sig_out_b, sig_out_a, valid_frame}), 16'h0005);
      check(16'({pd_out, pd_en, tx_win, pcm_en}), 16'h000F);
      repeat (6300) @(posedge clock);
      check(16'(heard), 16'h00A5);
      burst_ready <= 1'b0;
      $display("test frame finished");
      // Three bursts against a stalled modulator; inputs move after capture
      for (int k = 1; k <= 3; k++)
      begin
         {sig_b, sig_a} <= 2'(k);
         word <= 8'h30 + 8'(k);
         strobe(8'h50 + 8'(k), 2'(k), k != 3);
         check(16'(valid_frame), 16'(k != 3));
         @(posedge clock);
         {sig_b, sig_a} <= ~2'(k);
         repeat (k == 3 ? 1000 : 6300) @(posedge clock);
      end
      for (int k = 1; k <= 3; k++)
         pop(8'h2F + 8'(k), 2'(k), waited);
      repeat (4) @(posedge clock);
      check(16'(burst_valid), 16'h0000);
      repeat (5300) @(posedge clock);
      $display("test buffer finished");
      lb_n <= 1'b0;
      {sig_b, sig_a} <= 2'b01;
      strobe(8'hC3, 2'b00, 1'b1);
      pop(8'hC3, 2'b01, waited);
      check(16'(waited == 782 || waited == 783), 16'h0001);
      repeat (5500) @(posedge clock);
      check(16'(heard), 16'h0053);
      $display("test loopback finished");
      lb_n <= 1'b1;
      pd_ext <= 1'b0;
      strobe(8'h5A, 2'b01, 1'b1);
      check(16'({sig_out_b, sig_out_a, valid_frame}), 16'h0003);
      repeat (6300) @(posedge clock);
      check(16'({burst_valid, heard}), 16'h005A);
      repeat (6300) @(posedge clock);
      check(16'({valid_frame, pd_out, pd_en}), 16'h0001);
      {sig_b, sig_a} <= 2'b10;
      pd_ext <= 1'b1;
      pop(8'h33, 2'b10, waited);
      pd_ext <= 1'b0;
      $display("test silence finished");
      for (int m = 0; m < 2; m++)
      begin
         law <= m[0];
         tone <= 1'b1;
         // Second window close belongs to a frame begun under the new law
         repeat (2) @(negedge tx_win);
         @(posedge clock);
         pos = m[0] ? `TONE_MU_POS : `TONE_A_POS;
         neg = m[0] ? `TONE_MU_NEG : `TONE_A_NEG;
         check(16'(heard), 16'(heard === neg ? neg : pos));
      end
      tone <= 1'b0;
      $display("test tone finished");
      tally_and_finish();
   end
endmodule : tb_loop_slave_seq
`default_nettype wire
